// ==== design/epil_top.sv ====
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module epil_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // external pin
    input wire logic irq_pin_n,
    // cpu side
    input wire logic vector_fetch,
    input wire logic break_state,
    output logic cpu_irq_req,
    output logic [15:0] vec_hi_addr,
    output logic [15:0] vec_lo_addr,
    // axi4-lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import epil_pkg::*;

    // -------------------------------------------------------------------
    // front end and latch
    // -------------------------------------------------------------------
    epil_req_if req ();
    logic pending;
    logic ack;
    logic sw_ack;
    logic mode_q, mode_d, mask_q, mask_d, brk_clr_en_q, brk_clr_en_d;

    epil_pin_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .irq_pin_n(irq_pin_n),
        .req(req)
    );

    epil_latch u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .req(req),
        .mode(mode_q),
        .ack(ack),
        .pending(pending)
    );

    // -------------------------------------------------------------------
    // axi4-lite write channel
    // -------------------------------------------------------------------
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic w_strb0_q, w_strb0_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic do_write;

    // both halves may arrive in either order; commit once both are held
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb0_d = w_strb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        do_write = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            aw_addr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            w_data_d = s_axi_wdata;
            w_strb0_d = s_axi_wstrb[0];
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            do_write = 1'b1;
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            if (aw_addr_q == EPIL_STAT_CTRL_OFS ||
                aw_addr_q == EPIL_BRK_CTRL_OFS) begin
                bresp_d = EPIL_RESP_OKAY;
            end else if (aw_addr_q == EPIL_PIN_OFS ||
                aw_addr_q == EPIL_VEC_OFS) begin
                bresp_d = EPIL_RESP_OKAY; // read-only: write ignored
            end else begin
                bresp_d = EPIL_RESP_SLVERR;
            end
        end
        awready_d = !aw_have_d;
        wready_d = !w_have_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb0_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb0_q <= w_strb0_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // -------------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------------
    logic wr_sc, wr_brk;
    assign wr_sc = do_write && w_strb0_q && (aw_addr_q == EPIL_STAT_CTRL_OFS);
    assign wr_brk = do_write && w_strb0_q && (aw_addr_q == EPIL_BRK_CTRL_OFS);

    // ack bit is a strobe only, never stored, so it reads as zero
    always_comb begin
        mode_d = mode_q;
        mask_d = mask_q;
        brk_clr_en_d = brk_clr_en_q;
        if (wr_sc) begin
            mode_d = w_data_q[EPIL_MODE_BIT];
            mask_d = w_data_q[EPIL_MASK_BIT];
        end
        if (wr_brk) begin
            brk_clr_en_d = w_data_q[EPIL_BRK_CLR_EN_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= EPIL_MODE_RST;
            mask_q <= EPIL_MASK_RST;
            brk_clr_en_q <= EPIL_BRK_CLR_EN_RST;
        end else begin
            mode_q <= mode_d;
            mask_q <= mask_d;
            brk_clr_en_q <= brk_clr_en_d;
        end
    end

    // break state blocks software clears unless enabled
    assign sw_ack = wr_sc && w_data_q[EPIL_ACK_BIT] &&
        (!break_state || brk_clr_en_q);
    // vector fetch acknowledges as well
    assign ack = sw_ack | vector_fetch;

    // -------------------------------------------------------------------
    // cpu side outputs
    // -------------------------------------------------------------------
    logic irq_q, irq_d;
    always_comb begin
        irq_d = pending & ~mask_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
            vec_hi_addr <= 16'h0000;
            vec_lo_addr <= 16'h0000;
        end else begin
            irq_q <= irq_d;
            vec_hi_addr <= EPIL_VEC_HI_ADDR;
            vec_lo_addr <= EPIL_VEC_LO_ADDR;
        end
    end
    assign cpu_irq_req = irq_q;

    // -------------------------------------------------------------------
    // axi4-lite read channel
    // -------------------------------------------------------------------
    logic rvalid_q, rvalid_d, arready_q, arready_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    // one read in flight; address is taken only when no data is waiting
    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = EPIL_RESP_OKAY;
            rdata_d = 32'h0000_0000;
            case (s_axi_araddr)
                EPIL_STAT_CTRL_OFS: begin
                    rdata_d[EPIL_FLAG_BIT] = pending;
                    rdata_d[EPIL_MASK_BIT] = mask_q;
                    rdata_d[EPIL_MODE_BIT] = mode_q;
                end
                EPIL_BRK_CTRL_OFS: rdata_d[EPIL_BRK_CLR_EN_BIT] = brk_clr_en_q;
                EPIL_PIN_OFS: rdata_d[0] = req.pin_level;
                EPIL_VEC_OFS: rdata_d = {EPIL_VEC_HI_ADDR, EPIL_VEC_LO_ADDR};
                default: rresp_d = EPIL_RESP_SLVERR;
            endcase
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'b00;
        end else begin
            rvalid_q <= rvalid_d;
            arready_q <= arready_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule : epil_top
`default_nettype wire

// ==== pkg/epil_pkg.sv ====
package epil_pkg;
    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam logic [7:0] EPIL_STAT_CTRL_OFS = 8'h00;
    localparam logic [7:0] EPIL_BRK_CTRL_OFS = 8'h04;
    localparam logic [7:0] EPIL_PIN_OFS = 8'h08;
    localparam logic [7:0] EPIL_VEC_OFS = 8'h0C;
    // status/control field positions
    localparam int EPIL_MODE_BIT = 0;
    localparam int EPIL_MASK_BIT = 1;
    localparam int EPIL_ACK_BIT = 2;
    localparam int EPIL_FLAG_BIT = 3;
    // break control field position
    localparam int EPIL_BRK_CLR_EN_BIT = 0;
    // reset values
    localparam logic EPIL_MODE_RST = 1'b0;
    localparam logic EPIL_MASK_RST = 1'b0;
    localparam logic EPIL_BRK_CLR_EN_RST = 1'b0;
    // vector locations
    localparam logic [15:0] EPIL_VEC_HI_ADDR = 16'hFFFA;
    localparam logic [15:0] EPIL_VEC_LO_ADDR = 16'hFFFB;
    // axi response codes
    localparam logic [1:0] EPIL_RESP_OKAY = 2'b00;
    localparam logic [1:0] EPIL_RESP_SLVERR = 2'b10;
endpackage : epil_pkg

// ==== pkg/epil_req_if.sv ====
`timescale 1ns/10ps
`default_nettype none
// request path between pin front end and latch
interface epil_req_if;
    logic fall_pulse;
    logic pin_level;
    modport src (output fall_pulse, output pin_level);
    modport dst (input fall_pulse, input pin_level);
endinterface : epil_req_if
`default_nettype wire

// ==== design/epil_pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module epil_pin_sync (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // raw pin
    input wire logic irq_pin_n,
    // to latch
    epil_req_if.src req
);
    logic s1_q, s1_d, s2_q, s2_d, prev_q, prev_d;

    // chain keeps sampling in reset so a pin held low shows no false edge
    always_comb begin
        s1_d = irq_pin_n;
        s2_d = s1_q;
        prev_d = s2_q;
    end

    // power-up reset must span two edges so the chain fills before release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            prev_q <= s2_d; // history equals current: no pulse at release
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            prev_q <= prev_d;
        end
    end

    // compare current with previous sample
    assign req.fall_pulse = prev_q & ~s2_q;
    assign req.pin_level = s2_q;
endmodule : epil_pin_sync
`default_nettype wire

// ==== design/epil_latch.sv ====
`timescale 1ns/10ps
`default_nettype none
module epil_latch (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // from pin front end
    epil_req_if.dst req,
    // controls
    input wire logic mode,
    input wire logic ack,
    // state
    output logic pending
);
    logic lat_q, lat_d;

    // set wins over a clear in the same cycle
    always_comb begin
        lat_d = lat_q;
        if (ack) begin
            lat_d = 1'b0;
        end
        if (req.fall_pulse) begin
            lat_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_q <= 1'b0;
        end else begin
            lat_q <= lat_d;
        end
    end

    // low level keeps the request alive in edge-and-level mode
    assign pending = lat_q | (mode & ~req.pin_level);
endmodule : epil_latch
`default_nettype wire

// ==== bench/epil_props.sv ====
`timescale 1ns/10ps
`default_nettype none
// port watcher for the request latch block
module epil_props (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin and cpu side
    input wire logic irq_pin_n,
    input wire logic vector_fetch,
    input wire logic cpu_irq_req,
    input wire logic [15:0] vec_hi_addr,
    input wire logic [15:0] vec_lo_addr,
    // bus
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    import epil_pkg::*;
    logic [7:0] rd_addr_q;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // keep the read address so the data can be judged
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_q <= s_axi_araddr;
        end
    end
    property p_rst_quiet;
        disable iff (1'b0) !aresetn |=> !cpu_irq_req && !s_axi_rvalid;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("output active after reset");
    property p_vec;
        $past(aresetn) |-> vec_hi_addr == EPIL_VEC_HI_ADDR
            && vec_lo_addr == EPIL_VEC_LO_ADDR;
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector locations wrong");
    // pin quiet long enough that no edge is still in the synchroniser
    property p_fetch_clr;
        irq_pin_n [*6] ##0 vector_fetch |=> ##1 !cpu_irq_req;
    endproperty
    a_fetch_clr: assert property (p_fetch_clr)
        else $error("fetch left request up");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped");
    property p_ar_ans;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_ar_ans: assert property (p_ar_ans)
        else $error("read not answered");
    property p_ack_zero;
        s_axi_rvalid && rd_addr_q == EPIL_STAT_CTRL_OFS
            |-> !s_axi_rdata[EPIL_ACK_BIT] && s_axi_rdata[31:4] == 28'h0;
    endproperty
    a_ack_zero: assert property (p_ack_zero)
        else $error("ack bit reads one");
    property p_vec_rd;
        s_axi_rvalid && rd_addr_q == EPIL_VEC_OFS
            |-> s_axi_rdata == {EPIL_VEC_HI_ADDR, EPIL_VEC_LO_ADDR};
    endproperty
    a_vec_rd: assert property (p_vec_rd)
        else $error("vector word wrong");
endmodule : epil_props
`default_nettype wire

// ==== bench/epil_ext_dev.sv ====
`timescale 1ns/10ps
`default_nettype none
// external requester; the pin is pulled up whenever it lets go
module epil_ext_dev (
    // pacing clock
    input wire logic aclk,
    // request pin, active low
    output var logic irq_pin_n
);
    initial irq_pin_n = 1'b1;
    // one level change, launched just after an edge
    task automatic drive(input logic v);
        @(posedge aclk);
        irq_pin_n <= v;
    endtask : drive
endmodule : epil_ext_dev
`default_nettype wire

// ==== bench/epil_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module epil_top_tb_top;
    import epil_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] w;
        logic [1:0] r;
        logic [31:0] x;
    } epil_row_t;
    logic aclk, aresetn, irq_pin_n, vector_fetch, break_state, cpu_irq_req;
    logic [15:0] vec_hi_addr, vec_lo_addr;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int error_cnt, checks_done;
    epil_row_t rows [6];
    epil_top epil_top_inst (.aclk, .aresetn, .irq_pin_n, .vector_fetch,
        .break_state, .cpu_irq_req, .vec_hi_addr, .vec_lo_addr,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    epil_ext_dev epil_ext_dev_inst (.aclk, .irq_pin_n);
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    // a hang counts as a mismatch; about eighteen times the expected run
    initial begin
        #200000;
        error_cnt++;
        final_report();
    end
    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic chk_w(input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: exp %h got %h", $time, e, g);
        end
    endtask : chk_w
    task automatic chk_b(input logic e, input logic g);
        chk_w({31'h0, e}, {31'h0, g});
    endtask : chk_b
    // response is accepted a cycle late so the hold rule gets exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk_w(e, rd);
    endtask : rd_chk
    // pin change, then enough edges for sync, compare, latch and output
    task automatic pin(input logic v);
        epil_ext_dev_inst.drive(v);
        repeat (6) @(posedge aclk);
    endtask : pin
    task automatic fetch;
        @(posedge aclk);
        vector_fetch <= 1'b1;
        @(posedge aclk);
        vector_fetch <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask : fetch
    initial begin
        {aresetn, vector_fetch, break_state, s_axi_awvalid} = 4'h0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00F;
        rows = '{'{8'h00, 32'h3, EPIL_RESP_OKAY, 32'h3},
            '{8'h00, 32'h0, EPIL_RESP_OKAY, 32'h0},
            '{8'h04, 32'h1, EPIL_RESP_OKAY, 32'h1},
            '{8'h0C, 32'h0, EPIL_RESP_OKAY, 32'hFFFAFFFB},
            '{8'h08, 32'h0, EPIL_RESP_OKAY, 32'h1},
            '{8'h10, 32'hF, EPIL_RESP_SLVERR, 32'h0}};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(EPIL_STAT_CTRL_OFS, 32'h0);
        rd_chk(EPIL_BRK_CTRL_OFS, 32'h0);
        // a write without the low byte lane must leave the controls alone
        s_axi_wstrb <= 4'hE;
        wr(EPIL_STAT_CTRL_OFS, 32'h3);
        s_axi_wstrb <= 4'hF;
        rd_chk(EPIL_STAT_CTRL_OFS, 32'h0);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            chk_w({30'h0, rows[i].r}, {30'h0, rs});
            rd_chk(rows[i].a, rows[i].x);
            chk_w({30'h0, rows[i].r}, {30'h0, rs});
        end
        // edge mode: set, mask, unmask, fetch
        pin(1'b0);
        chk_b(1'b1, cpu_irq_req);
        pin(1'b1);
        rd_chk(8'h00, 32'h8);
        wr(8'h00, 32'h2);
        chk_b(1'b0, cpu_irq_req);
        rd_chk(8'h00, 32'hA);
        wr(8'h00, 32'h0);
        repeat (2) @(posedge aclk);
        chk_b(1'b1, cpu_irq_req);
        fetch();
        chk_b(1'b0, cpu_irq_req);
        rd_chk(8'h00, 32'h0);
        // software ack while the pin is still low, then a fresh edge
        pin(1'b0);
        wr(8'h00, 32'h4);
        rd_chk(8'h00, 32'h0);
        pin(1'b1);
        pin(1'b0);
        rd_chk(8'h00, 32'h8);
        pin(1'b1);
        // level mode, handler keeps requests masked
        wr(8'h00, 32'h3);
        pin(1'b0);
        wr(8'h00, 32'h7);
        rd_chk(8'h00, 32'hB);
        pin(1'b1);
        rd_chk(8'h00, 32'h3);
        pin(1'b0);
        pin(1'b1);
        rd_chk(8'h00, 32'hB);
        wr(8'h00, 32'h7);
        rd_chk(8'h00, 32'h3);
        // reset in mid-run with the pin held low
        wr(8'h00, 32'h1);
        pin(1'b0);
        chk_b(1'b1, cpu_irq_req);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk_b(1'b0, cpu_irq_req);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h00, 32'h0);
        // break state: ack blocked, then allowed
        pin(1'b1);
        pin(1'b0);
        break_state <= 1'b1;
        wr(8'h00, 32'h4);
        rd_chk(8'h00, 32'h8);
        wr(EPIL_BRK_CTRL_OFS, 32'h1);
        wr(8'h00, 32'h4);
        break_state <= 1'b0;
        rd_chk(8'h00, 32'h0);
        final_report();
    end
endmodule : epil_top_tb_top
bind epil_top epil_props epil_props_inst (.aclk, .aresetn, .irq_pin_n,
    .vector_fetch, .cpu_irq_req, .vec_hi_addr, .vec_lo_addr,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready);
`default_nettype wire
